// ### hw/lcigs_pkg.sv
// Shared constants for the logic cell input and gate select stage
package lcigs_pkg;
  // Sizes
  localparam int SEL_W      = 6;             // Source code width
  localparam int SRC_SPACE  = 2 ** SEL_W;    // Codes a selector can name
  localparam int NUM_CH     = 4;             // Data channels
  localparam int NUM_GATES  = 2;             // Gates built here
  localparam int REG_W      = 8;             // Register width
  localparam int WB_AW      = 8;             // Byte address width
  // Byte offsets on the bus
  localparam logic [WB_AW-1:0] OFS_SEL0 = 8'h00;
  localparam logic [WB_AW-1:0] OFS_SEL1 = 8'h04;
  localparam logic [WB_AW-1:0] OFS_SEL2 = 8'h08;
  localparam logic [WB_AW-1:0] OFS_SEL3 = 8'h0c;
  localparam logic [WB_AW-1:0] OFS_GLS0 = 8'h10;
  localparam logic [WB_AW-1:0] OFS_GLS1 = 8'h14;
  localparam logic [WB_AW-1:0] OFS_CTRL = 8'h18;
  localparam logic [WB_AW-1:0] OFS_STAT = 8'h1c;
  // Term enable pair inside a gate select register
  localparam int TERM_TRUE  = 1;             // Upper bit of a pair
  localparam int TERM_INV   = 0;             // Lower bit of a pair
  // Control register fields
  localparam int CTRL_EN    = 0;             // cell_enable
  localparam int CTRL_POL0  = 1;             // gate0_invert
  localparam int CTRL_W     = 3;             // Implemented control bits
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  // Status register fields
  localparam int STAT_CH    = 0;             // Channels at [3:0]
  localparam int STAT_GATE  = 4;             // Gates at [5:4]
  localparam int STAT_EN    = 6;             // Enable mirror
  // Bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } lcigs_bus_e;
endpackage : lcigs_pkg

// ### hw/lcigs_gate_term.sv
// One gate: OR of enabled true and inverted channel terms, then polarity
`timescale 1ns/1ps
module lcigs_gate_term #(
  parameter int NUM_CH = 4
) (
  // Channel signals
  input  wire logic [NUM_CH-1:0]   chan,
  // Term enables, one true/inverted pair per channel
  input  wire logic [2*NUM_CH-1:0] term_en,
  // Polarity control
  input  wire logic                invert,
  // Gate result
  output logic                     gate_val
);
  import lcigs_pkg::*;

  logic [NUM_CH-1:0] term;   // One term per channel

  // Each channel contributes its true and/or inverted form
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_term
      assign term[i] = (term_en[2*i+TERM_TRUE] & chan[i])
                     | (term_en[2*i+TERM_INV] & ~chan[i]);
    end
  endgenerate

  // No enabled term gives zero before polarity
  assign gate_val = (|term) ^ invert;
endmodule : lcigs_gate_term

// ### hw/lcigs_top.sv
// Logic cell input selection and gate term stage with Wishbone registers
//
// Contract
// - Four 6-bit source selectors, bits 5..0
// - Selector bits 7..6 ignore writes, read zero
// - Config registers undefined at power-on, kept otherwise
// - Gate 0 takes channel true form when enabled
// - Gate 0 takes channel inverted form when enabled
// - Cleared enable bit excludes that channel form
// - Gate 0 pairs: ch4 7/6 down to ch1 1/0
// - Gate 1 takes channel true form when enabled
// - Gate 1 takes channel inverted form when enabled
// - Gate 1 uses same pair layout as gate 0
// - Channel n delivers gate input n minus one
// - Per-gate polarity bit inverts the gate result
`timescale 1ns/1ps
module lcigs_top
  import lcigs_pkg::*;
#(
  parameter int NUM_SOURCES = 64  // Sources wired in, at most SRC_SPACE
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // Wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [lcigs_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Source signals from pins and peripherals
  input  wire logic [NUM_SOURCES-1:0]   source_in,
  // Channel signals toward the cell
  output logic [lcigs_pkg::NUM_CH-1:0]  gate_input,
  // Gate results after polarity
  output logic [lcigs_pkg::NUM_GATES-1:0] gate_out,
  // Cell enable toward the function core
  output logic                          cell_enable
);
  import lcigs_pkg::*;

  // Configuration storage, deliberately without reset
  logic [SEL_W-1:0]  sel_code [NUM_CH];     // Channel source codes
  logic [REG_W-1:0]  gate_en  [NUM_GATES];  // Gate term enables
  // Control storage with reset
  logic [CTRL_W-1:0] ctrl;                  // Enable and polarities
  // Bus slave state
  lcigs_bus_e        bus_state;             // Idle or acking
  lcigs_bus_e        next_bus_state;        // Next state
  // Source synchroniser stages
  logic [NUM_SOURCES-1:0] src_meta;         // First stage only
  logic [NUM_SOURCES-1:0] src_sync;         // Safe to use
  logic [SRC_SPACE-1:0]   src_pad;          // Zero filled code space
  // Selected channel values before the flop
  logic [NUM_CH-1:0]      next_chan;
  // Gate values before the flop
  logic [NUM_GATES-1:0]   gate_val;
  logic [NUM_GATES-1:0]   next_gate;

  // Decode wires
  logic bus_req;                 // Request awaiting answer
  logic wr_hit;                  // Write taken this edge
  logic lane0;                   // Low byte lane enabled
  logic hit_gls0;
  logic hit_gls1;
  logic hit_ctrl;
  logic [NUM_CH-1:0] hit_sel;    // Per selector address hit
  logic [31:0] rd_word;          // Read data before flop

  // Request present and not yet answered
  assign bus_req  = wb_cyc_i & wb_stb_i & (bus_state == BUS_IDLE);
  // Writes land on the edge the master sees ack
  assign wr_hit   = wb_cyc_i & wb_stb_i & wb_we_i & (bus_state == BUS_ACK);
  assign lane0    = wb_sel_i[0];
  assign hit_gls0 = (wb_adr_i == OFS_GLS0);
  assign hit_gls1 = (wb_adr_i == OFS_GLS1);
  assign hit_ctrl = (wb_adr_i == OFS_CTRL);
  assign hit_sel  = {wb_adr_i == OFS_SEL3, wb_adr_i == OFS_SEL2,
                     wb_adr_i == OFS_SEL1, wb_adr_i == OFS_SEL0};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0;
    case (1'b1)
      hit_sel[0]: rd_word = {26'h0, sel_code[0]};
      hit_sel[1]: rd_word = {26'h0, sel_code[1]};
      hit_sel[2]: rd_word = {26'h0, sel_code[2]};
      hit_sel[3]: rd_word = {26'h0, sel_code[3]};
      hit_gls0:   rd_word = {24'h0, gate_en[0]};
      hit_gls1:   rd_word = {24'h0, gate_en[1]};
      hit_ctrl:   rd_word = {29'h0, ctrl};
      (wb_adr_i == OFS_STAT): begin
        // Live view of the stage itself
        rd_word[STAT_CH +: NUM_CH]      = gate_input;
        rd_word[STAT_GATE +: NUM_GATES] = gate_out;
        rd_word[STAT_EN]                = cell_enable;
      end
      default:    rd_word = 32'h0;
    endcase
  end

  // Ack one cycle after the request, drop it the cycle after
  always_comb begin
    case (bus_state)
      BUS_IDLE: next_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  next_bus_state = BUS_IDLE;
      default:  next_bus_state = BUS_IDLE;
    endcase
  end

  // Bus state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  assign wb_ack_o = (bus_state == BUS_ACK);

  // Read data captured on the edge ack rises
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req) begin
      wb_dat_o <= wb_we_i ? 32'h0 : rd_word;
    end
  end

  // Selector registers; only bits 5..0 exist, srst leaves them alone
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_sel
      always_ff @(posedge core_clk) begin
        if (wr_hit && lane0 && hit_sel[c]) begin
          sel_code[c] <= wb_dat_i[SEL_W-1:0];
        end
      end
    end
  endgenerate

  // Gate select registers, kept across srst
  always_ff @(posedge core_clk) begin
    if (wr_hit && lane0 && hit_gls0) begin
      gate_en[0] <= wb_dat_i[REG_W-1:0];
    end
    if (wr_hit && lane0 && hit_gls1) begin
      gate_en[1] <= wb_dat_i[REG_W-1:0];
    end
  end

  // Control register; disabled after reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
    end else if (wr_hit && lane0 && hit_ctrl) begin
      ctrl <= wb_dat_i[CTRL_W-1:0];
    end
  end

  assign cell_enable = ctrl[CTRL_EN];

  // Sources are asynchronous to core_clk, two flops first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= source_in;
      src_sync <= src_meta;
    end
  end

  // Codes beyond the wired sources pick a constant zero
  assign src_pad = SRC_SPACE'(src_sync);

  // Each channel is a mux over the whole code space
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_mux
      assign next_chan[c] = src_pad[sel_code[c]];
    end
  endgenerate

  // Channel n drives gate input n-1; registered data output
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gate_input <= '0;
    end else begin
      gate_input <= next_chan;
    end
  end

  // Two gates, same layout, own polarity bit each
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++) begin : g_gate
      lcigs_gate_term #(
        .NUM_CH (NUM_CH)
      ) u_gate (
        .chan     (gate_input),
        .term_en  (gate_en[g]),
        .invert   (ctrl[CTRL_POL0 + g]),
        .gate_val (gate_val[g])
      );
    end
  endgenerate

  // Disabled cell holds gates low; also hides unwritten config
  assign next_gate = cell_enable ? gate_val : '0;

  // Registered gate outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gate_out <= '0;
    end else begin
      gate_out <= next_gate;
    end
  end

  // Helper views for the checks below
  logic [NUM_CH-1:0] g0_true;
  logic [NUM_CH-1:0] g0_inv;
  logic [NUM_CH-1:0] g1_true;
  logic [NUM_CH-1:0] g1_inv;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_view
      assign g0_true[c] = gate_en[0][2*c+TERM_TRUE];
      assign g0_inv[c]  = gate_en[0][2*c+TERM_INV];
      assign g1_true[c] = gate_en[1][2*c+TERM_TRUE];
      assign g1_inv[c]  = gate_en[1][2*c+TERM_INV];
    end
  endgenerate

  // Checks on the design's own outputs and config registers
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_ack_single_pulse: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");

  a_sel_write_lands: assert property (
    wr_hit && lane0 && hit_sel[2] |=> sel_code[2] == $past(wb_dat_i[SEL_W-1:0]))
    else $error("selector write not stored");

  a_sel_upper_zero: assert property (
    wb_ack_o && !wb_we_i && (|hit_sel) |-> wb_dat_o[7:6] == 2'h0)
    else $error("selector upper bits not zero");

  // Must be live during srst itself, so the default disable is overridden
  a_config_kept_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    srst |=> gate_en[0] === $past(gate_en[0]) && sel_code[0] === $past(sel_code[0]))
    else $error("config changed by srst");

  a_gate0_true_term: assert property (
    cell_enable && !ctrl[CTRL_POL0] && |(g0_true & gate_input) |=> gate_out[0])
    else $error("gate 0 missed a true term");

  a_gate0_inv_term: assert property (
    cell_enable && !ctrl[CTRL_POL0] && |(g0_inv & ~gate_input) |=> gate_out[0])
    else $error("gate 0 missed an inverted term");

  a_gate_no_terms: assert property (
    cell_enable && gate_en[0] == 8'h00 |=> gate_out[0] == $past(ctrl[CTRL_POL0]))
    else $error("gate 0 with no terms wrong");

  a_gate1_equation: assert property (
    cell_enable |=> gate_out[1] == $past((|(g1_true & gate_input) | |(g1_inv & ~gate_input))
                                         ^ ctrl[CTRL_POL0 + 1]))
    else $error("gate 1 result wrong");

  // Case equality: codes are unwritten until software sets them
  a_channel_map: assert property (
    1'b1 |=> gate_input[3] === $past(src_pad[sel_code[3]]))
    else $error("channel 4 not on gate input 3");

  a_disabled_low: assert property (
    !cell_enable |=> gate_out == '0)
    else $error("gates active while disabled");

  a_gate0_excluded: assert property (
    cell_enable && !ctrl[CTRL_POL0] && !(|(g0_true & gate_input)) && !(|(g0_inv & ~gate_input))
    |=> !gate_out[0])
    else $error("gate 0 high with no active term");

  a_gls1_readback: assert property (
    wb_ack_o && !wb_we_i && hit_gls1 |-> wb_dat_o[REG_W-1:0] == $past(gate_en[1]))
    else $error("gate 1 enables read back wrong");

  a_lane_ignored: assert property (
    wr_hit && !lane0 && hit_gls0 |=> gate_en[0] === $past(gate_en[0]))
    else $error("write without low lane landed");

  a_status_enable: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_STAT |-> wb_dat_o[STAT_EN] == $past(cell_enable))
    else $error("status enable mirror wrong");

  // Main scenarios
  c_sel_write: cover property (wr_hit && hit_sel[0]);
  c_gate0_high: cover property (cell_enable ##1 gate_out[0]);
  c_gate1_inverted: cover property (cell_enable && ctrl[CTRL_POL0 + 1] ##1 gate_out[1]);
  c_status_read: cover property (bus_req && !wb_we_i && wb_adr_i == OFS_STAT);
endmodule : lcigs_top

// ### tb/lcigs_source_model.sv
// Model of the pins and peripheral signals feeding the selectors
`timescale 1ns/1ps
module lcigs_source_model #(
  parameter int NUM_SOURCES = 48  // Sources modelled
) (
  // Clock
  input  wire logic                   core_clk,
  // Pattern chosen by the bench
  input  wire logic [5:0]             hot_idx,
  input  wire logic                   hot_level,
  // Sources toward the block
  output logic [NUM_SOURCES-1:0]      source_in
);
  // One source at the chosen level, all others inverse, so a wrong pick shows
  always_ff @(posedge core_clk) begin
    source_in <= hot_level ? (NUM_SOURCES'(1) << hot_idx) : ~(NUM_SOURCES'(1) << hot_idx);
  end
endmodule : lcigs_source_model

// ### tb/lcigs_top_test.sv
// Register and gate checks for the input and gate select stage
`timescale 1ns/1ps
module lcigs_top_test;
  import lcigs_pkg::*;
  // Sources wired in; codes above this must read zero
  localparam int NSRC = 48;
  logic                 core_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [WB_AW-1:0]     wb_adr_i = 8'h00;
  logic [31:0]          wb_dat_i = 32'h0;
  logic [3:0]           wb_sel_i = 4'h0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [NSRC-1:0]      source_in;
  logic [NUM_CH-1:0]    gate_input;
  logic [NUM_GATES-1:0] gate_out;
  logic                 cell_enable;
  logic [5:0]           hot_idx = 6'h00;
  logic                 hot_level = 1'b0;
  logic [31:0]          rd;
  logic [7:0]           g0;
  logic [7:0]           g1;
  int                   failures = 0;
  int                   comparisons = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  lcigs_top #(.NUM_SOURCES(NSRC)) dut_u (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_in(source_in),
    .gate_input(gate_input), .gate_out(gate_out), .cell_enable(cell_enable));
  lcigs_source_model #(.NUM_SOURCES(NSRC)) src_u (.core_clk(core_clk), .hot_idx(hot_idx),
    .hot_level(hot_level), .source_in(source_in));

  // Verdict and end of run
  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Compare a register read
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  // Compare a level output
  task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask : chk_out

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("Error at %0t: bus timeout", $time);
      end_sim();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb_xfer(1'b1, adr, dat, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 8'h00, 4'h1);
    chk_reg(rd, exp);
  endtask : rd_chk

  // OR of enabled terms worked out independently
  function automatic logic exp_gate(input logic [7:0] en, input logic [3:0] ch);
    logic [7:0] t;
    for (int i = 0; i < 4; i++) begin
      t[2*i+1] = ch[i];
      t[2*i] = ~ch[i];
    end
    return |(en & t);
  endfunction : exp_gate

  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    // Selector fields and the read-zero upper bits
    for (int n = 0; n < 4; n++) begin
      wr(OFS_SEL0 + 8'(4*n), 8'hff);
      rd_chk(OFS_SEL0 + 8'(4*n), 32'h3f);
    end
    wr(OFS_GLS0, 8'ha5);
    rd_chk(OFS_GLS0, 32'ha5);
    wr(OFS_GLS1, 8'h5a);
    rd_chk(OFS_GLS1, 32'h5a);
    wb_xfer(1'b1, OFS_GLS0, 8'h00, 4'h2);
    rd_chk(OFS_GLS0, 32'ha5);
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 32'h0);
    // Settings survive a mid-run reset
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd_chk(OFS_GLS0, 32'ha5);
    rd_chk(OFS_SEL3, 32'h3f);
    chk_out({3'h0, cell_enable}, 4'h0);
    $display("Test registers done");
    // Channel n follows its selected source; unwired code reads zero
    wr(OFS_CTRL, 8'h00);
    for (int n = 0; n < 4; n++) wr(OFS_SEL0 + 8'(4*n), 8'h0a + 8'(n));
    for (int n = 0; n < 4; n++) begin
      hot_idx <= 6'h0a + 6'(n);
      hot_level <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk_out(gate_input, 4'h1 << n);
      hot_level <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk_out(gate_input, ~(4'h1 << n));
    end
    wr(OFS_SEL0, 8'h3f);
    repeat (6) @(posedge core_clk);
    chk_out(gate_input, 4'h6);
    wr(OFS_SEL0, 8'h0a);
    $display("Test channels done");
    // Each single term in both gates, with channel pattern 0010
    hot_idx <= 6'h0b;
    hot_level <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      g0 = 8'h01 << b;
      g1 = 8'h80 >> b;
      wr(OFS_CTRL, 8'h00);
      wr(OFS_GLS0, g0);
      wr(OFS_GLS1, g1);
      wr(OFS_CTRL, 8'h01);
      repeat (4) @(posedge core_clk);
      chk_out({2'h0, gate_out}, {2'h0, exp_gate(g1, 4'h2), exp_gate(g0, 4'h2)});
    end
    chk_out({3'h0, cell_enable}, 4'h1);
    // No terms gives zero, then each gate polarity, status view, then disabled
    wr(OFS_CTRL, 8'h00);
    wr(OFS_GLS0, 8'h00);
    wr(OFS_GLS1, 8'h00);
    wr(OFS_CTRL, 8'h01);
    repeat (4) @(posedge core_clk);
    chk_out({2'h0, gate_out}, 4'h0);
    wr(OFS_CTRL, 8'h03);
    repeat (4) @(posedge core_clk);
    chk_out({2'h0, gate_out}, 4'h1);
    wr(OFS_CTRL, 8'h05);
    repeat (4) @(posedge core_clk);
    chk_out({2'h0, gate_out}, 4'h2);
    rd_chk(OFS_STAT, 32'h62);
    wr(OFS_CTRL, 8'h02);
    repeat (4) @(posedge core_clk);
    chk_out({2'h0, gate_out}, 4'h0);
    rd_chk(OFS_STAT, 32'h02);
    $display("Test gates done");
    end_sim();
  end
endmodule : lcigs_top_test
